//--- inc/wake_ctrl_pkg.sv
// Package for the secondary processor wake-up gating block
package wake_ctrl_pkg;

	// ****************************************************************
	// Wake gating states
	// ****************************************************************
	typedef enum logic [1:0]
	{
		ST_HALTED,
		ST_RUNNING,
		ST_RESTART
	} wake_state_e;

	// ****************************************************************
	// Message strobes from the local interrupt unit
	// ****************************************************************
	typedef struct packed
	{
		logic restart_msg;
		logic wake_message;
	} msg_in_s;

	// Run status toward the core
	typedef struct packed
	{
		logic fetch_enable;
		logic restart_core;
		logic restart_pending;
	} core_ctl_s;

	localparam logic [2:0] CORE_CTL_RESET = 3'h0;
	localparam logic [1:0] SYNC_RESET     = 2'h0;

endpackage : wake_ctrl_pkg

//--- logic/secondary_cpu_wakeup_control.sv
// Wake-up and warm-restart gating for a processor core
// Summary of operation
// - After hard reset or warm restart a secondary halts, no reset-vector fetch.
// - Secondary leaves the halted state only on a wake message.
// - Warm-restart pin and warm-restart message both count as warm restart.
// - Warm-restart message while halted is held pending until wake arrives.
// - After wake, restarts are acted on and further wakes discarded.
// - Wakes stay ignored until hard reset or warm restart rearms them.
// - A primary processor ignores every wake message without state change.
module secondary_cpu_wakeup_control
	import wake_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     reset_n,
	// Role and warm-restart pin
	input  wire logic                     secondary_role,
	input  wire logic                     restart_pin,
	// Message strobes
	input  wire wake_ctrl_pkg::msg_in_s   msg_in,
	// Core control
	output logic                          fetch_enable,
	output logic                          restart_core,
	output logic                          restart_pending
);
	import wake_ctrl_pkg::*;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [1:0]  pin_sync_reg;
	logic [1:0]  pin_sync_next;
	logic [1:0]  role_sync_reg;
	logic [1:0]  role_sync_next;
	logic        pin_prev_reg;
	logic        pin_prev_next;

	always_comb
	begin
		pin_sync_next  = {pin_sync_reg[0], restart_pin};
		role_sync_next = {role_sync_reg[0], secondary_role};
		pin_prev_next  = pin_sync_reg[1];
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			pin_sync_reg  <= SYNC_RESET;
			pin_prev_reg  <= 1'b0;
		end
		else
		begin
			pin_sync_reg  <= pin_sync_next;
			pin_prev_reg  <= pin_prev_next;
		end
	end

	// Role sync runs through reset, settled at release
	always_ff @(posedge clk_sys)
	begin
		role_sync_reg <= role_sync_next;
	end

	logic is_secondary;
	logic pin_rise;
	logic warm_restart;

	assign is_secondary = role_sync_reg[1];
	assign pin_rise     = pin_sync_reg[1] & ~pin_prev_reg;
	// Pin edge and message are the same event
	assign warm_restart = pin_rise | msg_in.restart_msg;

	// ****************************************************************
	// Wake gating state machine
	// ****************************************************************
	wake_state_e state_reg;
	wake_state_e state_next;
	core_ctl_s   ctl_reg;
	core_ctl_s   ctl_next;

	always_comb
	begin
		state_next           = state_reg;
		ctl_next             = ctl_reg;
		ctl_next.restart_core = 1'b0;
		case (state_reg)
			ST_HALTED:
			begin
				ctl_next.fetch_enable = 1'b0;
				if (!is_secondary)
				begin
					// Primary role runs at once
					state_next            = ST_RUNNING;
					ctl_next.fetch_enable = 1'b1;
				end
				else if (pin_rise)
				begin
					// Pin restart re-enters the halt directly
					ctl_next.restart_core = 1'b1;
				end
				else if (msg_in.wake_message)
				begin
					state_next            = ST_RUNNING;
					ctl_next.fetch_enable = 1'b1;
					if (ctl_reg.restart_pending || msg_in.restart_msg)
					begin
						// Act on held restart, then halt again
						state_next              = ST_RESTART;
						ctl_next.fetch_enable   = 1'b0;
					end
				end
				else if (msg_in.restart_msg)
				begin
					ctl_next.restart_pending = 1'b1;
				end
			end
			ST_RUNNING:
			begin
				// Wakes are discarded here
				if (is_secondary && warm_restart)
				begin
					state_next            = ST_RESTART;
					ctl_next.fetch_enable = 1'b0;
				end
			end
			ST_RESTART:
			begin
				// Restart core, rearm wake; a new message stays pending
				ctl_next.restart_core    = 1'b1;
				ctl_next.restart_pending = msg_in.restart_msg;
				ctl_next.fetch_enable    = 1'b0;
				state_next               = ST_HALTED;
			end
			default:
			begin
				state_next = ST_HALTED;
				ctl_next   = CORE_CTL_RESET;
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			state_reg <= ST_HALTED;
			ctl_reg   <= CORE_CTL_RESET;
		end
		else
		begin
			state_reg <= state_next;
			ctl_reg   <= ctl_next;
		end
	end

	assign fetch_enable    = ctl_reg.fetch_enable;
	assign restart_core    = ctl_reg.restart_core;
	assign restart_pending = ctl_reg.restart_pending;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_halt_after_reset: assert property (@(posedge clk_sys)
		$rose(reset_n) |-> !fetch_enable)
		else $error("fetch enabled right after reset");

	a_wake_only_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_reg == ST_HALTED && is_secondary && !msg_in.wake_message)
		|=> !fetch_enable)
		else $error("secondary ran without a wake");

	a_pending_held: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(restart_pending && state_reg == ST_HALTED && !msg_in.wake_message && is_secondary)
		|=> restart_pending)
		else $error("pending restart lost while halted");

	a_wake_ignored_run: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_reg == ST_RUNNING && !warm_restart) |=> state_reg == ST_RUNNING && fetch_enable)
		else $error("wake disturbed running core");

	a_restart_rearms: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_reg == ST_RUNNING && is_secondary && warm_restart)
		|=> ##1 restart_core && state_reg == ST_HALTED)
		else $error("restart did not rearm wake");

	a_primary_runs: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_reg == ST_RUNNING && !is_secondary) |=> fetch_enable)
		else $error("primary halted");

	a_pending_clears: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_reg == ST_RESTART && !msg_in.restart_msg)
		|=> restart_core && !restart_pending)
		else $error("pending flag not cleared on restart");

	a_pin_counts: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_reg == ST_RUNNING && is_secondary && pin_rise) |=> !fetch_enable)
		else $error("pin restart ignored");

	a_wake_starts_run: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_reg == ST_HALTED && is_secondary && !pin_rise && msg_in.wake_message
			&& !restart_pending && !msg_in.restart_msg)
		|=> fetch_enable && state_reg == ST_RUNNING)
		else $error("wake did not start secondary");

	a_pending_acted: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_reg == ST_HALTED && is_secondary && !pin_rise && msg_in.wake_message
			&& restart_pending)
		|=> !fetch_enable ##1 restart_core)
		else $error("held restart not acted on at wake");

	a_restart_no_queue: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_reg == ST_HALTED && is_secondary && !pin_rise && !msg_in.wake_message
			&& msg_in.restart_msg)
		|=> restart_pending && !restart_core && !fetch_enable)
		else $error("restart message not held as one flag");

	a_primary_ignores: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_reg == ST_RUNNING && !is_secondary && msg_in.wake_message)
		|=> state_reg == ST_RUNNING && fetch_enable && !restart_core)
		else $error("primary reacted to a wake");

endmodule : secondary_cpu_wakeup_control

//--- verif/boot_cpu_model.sv
// Boot processor model that sends the wake sequence
module boot_cpu_model
	import wake_ctrl_pkg::*;
#(
	parameter int RESTART_WAIT = 100,
	parameter int WAKE_WAIT    = 20
)
(
	input  wire logic              clk_sys,
	input  wire logic              go,
	output wake_ctrl_pkg::msg_in_s msg,
	output logic                   done
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		msg = '0;
		done = 1'b0;
		forever
		begin
			@(negedge clk_sys);
			if (go)
			begin
				msg.restart_msg = 1'b1;
				@(negedge clk_sys);
				msg = '0;
				repeat (RESTART_WAIT) @(negedge clk_sys);
				repeat (2)
				begin
					msg.wake_message = 1'b1;
					@(negedge clk_sys);
					msg = '0;
					repeat (WAKE_WAIT) @(negedge clk_sys);
				end
				done = 1'b1;
				@(negedge clk_sys);
				done = 1'b0;
			end
		end
	end
endmodule : boot_cpu_model

//--- verif/secondary_cpu_wakeup_control_tb.sv
// Self-checking bench for the wake-up gating block
module secondary_cpu_wakeup_control_tb;
	import wake_ctrl_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic    clk_sys = 1'b0;
	logic    reset_n = 1'b0;
	logic    secondary_role = 1'b1;
	logic    restart_pin = 1'b0;
	logic    go = 1'b0;
	logic    done;
	msg_in_s tb_msg = '0;
	msg_in_s bp_msg;
	logic    fetch_enable;
	logic    restart_core;
	logic    restart_pending;
	int      err_count = 0;
	int      samples_checked = 0;
	int      pulses;
	int      n;
	int      k;
	logic    rnd_wake;
	logic    exp_run;
	logic    exp_pend;
	logic    exp_pulse;
	always #5 clk_sys = ~clk_sys;
	boot_cpu_model i_boot_cpu_model (.clk_sys(clk_sys), .go(go), .msg(bp_msg), .done(done));
	secondary_cpu_wakeup_control i_secondary_cpu_wakeup_control (.clk_sys(clk_sys),
		.reset_n(reset_n), .secondary_role(secondary_role), .restart_pin(restart_pin),
		.msg_in(tb_msg | bp_msg), .fetch_enable(fetch_enable),
		.restart_core(restart_core), .restart_pending(restart_pending));
	task automatic chk(input logic got, input logic exp, input string s);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t %s", $time, s);
		end
	endtask : chk
	// Next run, next pending, restart pulse for one message
	function automatic logic [2:0] predict(input logic run, input logic pend, input logic wake);
		if (run)
			return wake ? 3'b100 : 3'b001;
		if (wake)
			return pend ? 3'b001 : 3'b100;
		return 3'b010;
	endfunction : predict
	task automatic settle(input int c, input int exp_p);
		pulses = 0;
		repeat (c)
		begin
			@(negedge clk_sys);
			if (restart_core === 1'b1) pulses++;
		end
		chk(pulses == exp_p, 1'b1, "pulse count");
	endtask : settle
	task automatic send(input logic wake, input int exp_p);
		repeat ($urandom_range(2, 0)) @(negedge clk_sys);
		@(negedge clk_sys);
		tb_msg = {~wake, wake};
		@(negedge clk_sys);
		tb_msg = '0;
		settle(6, exp_p);
	endtask : send
	task automatic do_reset(input logic role);
		@(negedge clk_sys);
		reset_n = 1'b0;
		secondary_role = role;
		repeat (4) @(negedge clk_sys);
		reset_n = 1'b1;
		settle(6, 0);
	endtask : do_reset
	task automatic results();
		$display("checked %0d bad %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results
	initial
	begin
		repeat (2000) @(posedge clk_sys);
		err_count++;
		results();
	end
	initial
	begin
		void'($urandom(50023));
		do_reset(1'b1);
		chk(fetch_enable, 1'b0, "halt");
		@(posedge clk_sys) go <= 1'b1;
		@(posedge clk_sys) go <= 1'b0;
		for (n = 0; n < 400 && done !== 1'b1; n++) @(posedge clk_sys);
		chk(done, 1'b1, "boot done");
		chk(fetch_enable, 1'b1, "woken");
		$display("end boot");
		send(1'b1, 0);
		chk(fetch_enable, 1'b1, "wake ignored");
		send(1'b0, 1);
		chk(fetch_enable, 1'b0, "restart");
		send(1'b1, 0);
		chk(fetch_enable, 1'b1, "rearm");
		$display("end rerun");
		send(1'b0, 1);
		repeat ($urandom_range(3, 1)) send(1'b0, 0);
		chk(restart_pending, 1'b1, "pending");
		chk(fetch_enable, 1'b0, "held");
		send(1'b1, 1);
		chk(restart_pending, 1'b0, "pend clr");
		send(1'b1, 0);
		chk(fetch_enable, 1'b1, "run");
		$display("end pending");
		@(negedge clk_sys);
		restart_pin = 1'b1;
		settle(9, 1);
		restart_pin = 1'b0;
		chk(fetch_enable, 1'b0, "pin");
		send(1'b1, 0);
		chk(fetch_enable, 1'b1, "pin rearm");
		$display("end pin");
		exp_run = 1'b1;
		exp_pend = 1'b0;
		for (k = 0; k < 24; k++)
		begin
			rnd_wake = 1'($urandom_range(1, 0));
			{exp_run, exp_pend, exp_pulse} = predict(exp_run, exp_pend, rnd_wake);
			send(rnd_wake, int'(exp_pulse));
			chk(fetch_enable, exp_run, "random run");
			chk(restart_pending, exp_pend, "random pend");
		end
		$display("end random");
		do_reset(1'b0);
		chk(fetch_enable, 1'b1, "primary");
		send(1'b1, 0);
		chk(fetch_enable, 1'b1, "primary wake");
		$display("end primary");
		results();
	end
endmodule : secondary_cpu_wakeup_control_tb
